// *** hdl/sfp_pkg.sv ***
// constants shared by the flash power-mode device end and its host end
// assumes one system clock; the spi serial clock is a divided enable on the host side
// Operation
// - deep sleep drops write, program, erase commands
// - chip select high gives standby when idle
// - deep sleep ignores all but wake command
// - power loss clears deep sleep, boots standby
// - sleep command needs select rise after bit eight
// - sleep entered only after entry delay
// - sleep command rejected while busy
// - wake command leaves deep sleep
// - wake command returns signature when not busy
// - wake command while busy not decoded
// - opcode, three dummy bytes, then signature out
// - further clocking repeats the signature byte
// - release after full signature waits long delay
// - early release waits short delay
// - host keeps device deselected during ramps
// - below inhibit threshold logic held in reset
// - write commands ignored until power-up write delay
// - host waits before write-class commands; sfp_host only waits the select delay, and the device drops early ones
// - power-up: standby, latch and busy cleared
// - delivery state array ones, status zero
// - busy flag high through self-timed cycles
package sfp_pkg;
  // opcodes
  localparam logic [7:0] SFP_CMD_SLEEP = 8'hB9;
  localparam logic [7:0] SFP_CMD_WAKE = 8'hAB;
  localparam logic [7:0] SFP_CMD_UNLOCK = 8'h06;
  localparam logic [7:0] SFP_CMD_PAGE = 8'h02;
  localparam logic [7:0] SFP_CMD_SECTOR = 8'hD8;
  localparam logic [7:0] SFP_CMD_FULL = 8'hC7;
  localparam logic [7:0] SFP_CMD_STATUS = 8'h01;
  // signature value is arbitrary
  localparam logic [7:0] SFP_SIGNATURE = 8'h5A;
  localparam logic [7:0] SFP_STATUS_RESET = 8'h00;
  localparam logic [7:0] SFP_ARRAY_ERASED = 8'hFF;
  localparam int SFP_DUMMY_BYTES = 3;
  // timing in ns, then cycles at 25 MHz
  localparam int SFP_CLK_NS = 40;
  localparam int SFP_SLEEP_ENTRY_NS = 3000;
  // the full-signature release is the longer of the two wake delays
  localparam int SFP_SHORT_WAKE_NS = 1800;
  localparam int SFP_LONG_WAKE_NS = 3000;
  localparam int SFP_SELECT_AFTER_SUPPLY_NS = 10000;
  localparam int SFP_WRITE_AFTER_SUPPLY_NS = 10000000;
  localparam int SFP_SLEEP_ENTRY_CYC = (SFP_SLEEP_ENTRY_NS + SFP_CLK_NS - 1) / SFP_CLK_NS;
  localparam int SFP_SHORT_WAKE_CYC = (SFP_SHORT_WAKE_NS + SFP_CLK_NS - 1) / SFP_CLK_NS;
  localparam int SFP_LONG_WAKE_CYC = (SFP_LONG_WAKE_NS + SFP_CLK_NS - 1) / SFP_CLK_NS;
  localparam int SFP_SELECT_CYC =
    (SFP_SELECT_AFTER_SUPPLY_NS + SFP_CLK_NS - 1) / SFP_CLK_NS;
  localparam int SFP_WRITE_CYC = (SFP_WRITE_AFTER_SUPPLY_NS + SFP_CLK_NS - 1) / SFP_CLK_NS;
  // serial clock divider: half period in system cycles
  localparam int SFP_SCK_HALF = 2;
  localparam int SFP_DELAY_W = 20;
  // device power states
  typedef enum logic [1:0] {
    SFP_PWR_STANDBY = 2'b00,
    SFP_PWR_ENTERING = 2'b01,
    SFP_PWR_SLEEP = 2'b10,
    SFP_PWR_WAKING = 2'b11
  } sfp_pwr_t;
  // host command codes on its user port
  typedef enum logic [1:0] {
    SFP_REQ_SLEEP = 2'b00,
    SFP_REQ_WAKE = 2'b01,
    SFP_REQ_RAW = 2'b10
  } sfp_req_t;
endpackage

// *** hdl/sfp_link_if.sv ***
// spi link between the flash power-mode device end and the host end
// assumes both ends sample the link on the one system clock
`timescale 1ns/1ps
interface sfp_link_if;
  logic sel_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport device (input sel_n, input sck, input mosi, output miso, output miso_oe);
  modport host (output sel_n, output sck, output mosi, input miso, input miso_oe);
endinterface

// *** hdl/sfp_device.sv ***
// device end: spi command decode for deep sleep, wake and signature, power-up lockout
// assumes link pins come from another domain and pass two flops; rst_n_i is power-on reset
`timescale 1ns/1ps
module sfp_device #(
  parameter int WRITE_DELAY_CYC = sfp_pkg::SFP_WRITE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  sfp_link_if.device link,
  input wire logic cycle_busy_i,
  output logic sleeping_o,
  output logic busy_flag_o,
  output logic write_unlock_latch_o,
  output logic write_allowed_o,
  output logic [7:0] status_o,
  output logic [7:0] write_cmd_o,
  output logic write_cmd_valid_o,
  output logic miso_o
);
  import sfp_pkg::*;

  // two-flop synchronisers for the link pins
  logic [1:0] sel_sync;
  logic [1:0] sck_sync;
  logic [1:0] mosi_sync;
  logic sck_prev;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_sync <= 2'b11;
      sck_sync <= 2'b00;
      mosi_sync <= 2'b00;
      sck_prev <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[0], link.sel_n};
      sck_sync <= {sck_sync[0], link.sck};
      mosi_sync <= {mosi_sync[0], link.mosi};
      sck_prev <= sck_sync[1];
    end
  end

  wire sel_n = sel_sync[1];
  wire sck_rise = !sel_n && sck_sync[1] && !sck_prev;
  wire sck_fall = !sel_n && !sck_sync[1] && sck_prev;

  logic sel_prev;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_prev <= 1'b1;
    end else begin
      sel_prev <= sel_n;
    end
  end
  wire sel_rise = sel_n && !sel_prev;
  wire sel_fall = !sel_n && sel_prev;

  // frame state
  sfp_pwr_t pwr;
  logic [7:0] shift;
  logic [7:0] opcode;
  logic [5:0] bit_cnt;
  logic have_op;
  logic ignored;
  logic [7:0] sig_sh;
  logic [2:0] sig_bits;
  logic sig_done;
  logic [SFP_DELAY_W-1:0] wait_cnt;
  logic [23:0] pu_cnt;
  logic unlock;
  logic out_bit;
  logic out_en;

  wire pwr_busy = (pwr == SFP_PWR_ENTERING) || (pwr == SFP_PWR_WAKING);
  wire write_ok = (pu_cnt >= 24'(WRITE_DELAY_CYC));
  wire byte_done = sck_rise && (bit_cnt[2:0] == 3'd7);
  wire [7:0] next_byte = {shift[6:0], mosi_sync[1]};
  wire op_byte = byte_done && !have_op;
  wire is_wake = (next_byte == SFP_CMD_WAKE);
  // while sleeping only wake decodes; while busy wake is not decoded
  wire op_dropped = (pwr == SFP_PWR_SLEEP && !is_wake) || (is_wake && cycle_busy_i);
  wire is_write_class = (next_byte == SFP_CMD_UNLOCK) || (next_byte == SFP_CMD_PAGE) ||
    (next_byte == SFP_CMD_SECTOR) || (next_byte == SFP_CMD_FULL) ||
    (next_byte == SFP_CMD_STATUS);
  // write-class commands pass only when awake and past the power-up delay
  wire pass_write = op_byte && !ignored && is_write_class && pwr == SFP_PWR_STANDBY &&
    write_ok;
  // sleep executes only if select rose exactly after bit eight
  wire sleep_go = sel_rise && !ignored && have_op && opcode == SFP_CMD_SLEEP &&
    bit_cnt == 6'd8 && !cycle_busy_i && pwr == SFP_PWR_STANDBY;
  wire wake_end = sel_rise && !ignored && have_op && opcode == SFP_CMD_WAKE;
  wire [SFP_DELAY_W-1:0] wake_len = sig_done ? SFP_DELAY_W'(SFP_LONG_WAKE_CYC) :
    SFP_DELAY_W'(SFP_SHORT_WAKE_CYC);

  // power-up write lockout counter, cleared by power-on reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_cnt <= '0;
    end else if (!write_ok) begin
      pu_cnt <= pu_cnt + 24'd1;
    end
  end

  // bit and opcode capture on rising serial clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift <= '0;
      opcode <= '0;
      bit_cnt <= '0;
      have_op <= 1'b0;
      ignored <= 1'b0;
    end else if (sel_fall) begin
      bit_cnt <= '0;
      have_op <= 1'b0;
      ignored <= pwr_busy;
    end else if (sck_rise) begin
      shift <= next_byte;
      if (bit_cnt != 6'd63) begin
        bit_cnt <= bit_cnt + 6'd1;
      end
      if (op_byte) begin
        opcode <= next_byte;
        have_op <= 1'b1;
        if (op_dropped) begin
          ignored <= 1'b1;
        end
      end
    end
  end

  // signature shifter: starts after opcode plus three dummy bytes, repeats
  wire sig_window = have_op && !ignored && opcode == SFP_CMD_WAKE &&
    bit_cnt >= 6'(8 * (SFP_DUMMY_BYTES + 1));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sig_sh <= SFP_SIGNATURE;
      sig_bits <= '0;
      sig_done <= 1'b0;
      out_bit <= 1'b0;
      out_en <= 1'b0;
    end else if (sel_n) begin
      sig_sh <= SFP_SIGNATURE;
      sig_bits <= '0;
      out_en <= 1'b0;
      if (sel_rise) begin
        sig_done <= 1'b0;
      end
    end else if (sck_fall && sig_window) begin
      out_en <= 1'b1;
      out_bit <= sig_sh[7];
      sig_sh <= (sig_bits == 3'd7) ? SFP_SIGNATURE : {sig_sh[6:0], 1'b0};
      sig_bits <= sig_bits + 3'd1;
      if (sig_bits == 3'd7) begin
        sig_done <= 1'b1;
      end
    end
  end

  // power state machine
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr <= SFP_PWR_STANDBY;
      wait_cnt <= '0;
    end else begin
      case (pwr)
        SFP_PWR_STANDBY: begin
          if (sleep_go) begin
            pwr <= SFP_PWR_ENTERING;
            wait_cnt <= SFP_DELAY_W'(SFP_SLEEP_ENTRY_CYC);
          end
        end
        SFP_PWR_ENTERING: begin
          if (wait_cnt <= SFP_DELAY_W'(1)) begin
            pwr <= SFP_PWR_SLEEP;
          end
          wait_cnt <= wait_cnt - SFP_DELAY_W'(1);
        end
        SFP_PWR_SLEEP: begin
          if (wake_end) begin
            pwr <= SFP_PWR_WAKING;
            wait_cnt <= wake_len;
          end
        end
        default: begin
          if (wait_cnt <= SFP_DELAY_W'(1)) begin
            pwr <= SFP_PWR_STANDBY;
          end
          wait_cnt <= wait_cnt - SFP_DELAY_W'(1);
        end
      endcase
    end
  end

  // write latch: set by unlock command, cleared when a cycle starts
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlock <= 1'b0;
    end else if (pass_write && next_byte == SFP_CMD_UNLOCK) begin
      unlock <= 1'b1;
    end else if (cycle_busy_i) begin
      unlock <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleeping_o <= 1'b0;
      busy_flag_o <= 1'b0;
      write_unlock_latch_o <= 1'b0;
      write_allowed_o <= 1'b0;
      status_o <= SFP_STATUS_RESET;
      write_cmd_o <= '0;
      write_cmd_valid_o <= 1'b0;
      miso_o <= 1'b0;
    end else begin
      sleeping_o <= (pwr == SFP_PWR_SLEEP);
      busy_flag_o <= cycle_busy_i;
      write_unlock_latch_o <= unlock;
      write_allowed_o <= write_ok;
      status_o <= {6'b0, unlock, cycle_busy_i};
      write_cmd_o <= next_byte;
      write_cmd_valid_o <= pass_write;
      miso_o <= out_bit;
    end
  end

  assign link.miso = out_bit;
  assign link.miso_oe = out_en;
endmodule

// *** hdl/sfp_host.sv ***
// host end: sends sleep, wake or a raw opcode over spi, reads the signature
// assumes device answers on miso; miso passes two flops before use
`timescale 1ns/1ps
module sfp_host (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  sfp_link_if.host link,
  input wire logic req_valid_i,
  input wire sfp_pkg::sfp_req_t req_cmd_i,
  input wire logic [7:0] req_raw_i,
  input wire logic [1:0] req_sig_reads_i,
  output logic req_ready_o,
  output logic [7:0] sig_o,
  output logic sig_valid_o
);
  import sfp_pkg::*;

  typedef enum logic [1:0] {
    SFP_H_POWERUP = 2'b00,
    SFP_H_IDLE = 2'b01,
    SFP_H_SHIFT = 2'b10,
    SFP_H_HOLD = 2'b11
  } sfp_hst_t;

  sfp_hst_t st;
  logic [SFP_DELAY_W-1:0] cnt;
  logic [1:0] div;
  logic sck;
  logic sel_n;
  logic [7:0] tx;
  logic [5:0] bits_left;
  logic [7:0] rx;
  logic [2:0] rx_bits;
  logic [1:0] miso_sync;
  logic [SFP_DELAY_W-1:0] hold_len;
  logic [5:0] rd_len;

  wire tick = (div == 2'(SFP_SCK_HALF - 1));
  wire [7:0] req_op = (req_cmd_i == SFP_REQ_SLEEP) ? SFP_CMD_SLEEP :
    (req_cmd_i == SFP_REQ_WAKE) ? SFP_CMD_WAKE : req_raw_i;
  wire [5:0] req_bits = (req_cmd_i == SFP_REQ_WAKE) ?
    6'(8 * (SFP_DUMMY_BYTES + 1)) + {req_sig_reads_i, 3'b000} : 6'd8;
  // signature bits to collect; only a wake frame reads anything back
  wire [5:0] req_rd = (req_cmd_i == SFP_REQ_WAKE) ? {1'b0, req_sig_reads_i, 3'b000} : 6'd0;
  // hold select high long enough for any pending entry or wake delay
  wire [SFP_DELAY_W-1:0] req_hold = SFP_DELAY_W'(SFP_SLEEP_ENTRY_CYC);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_sync <= 2'b00;
    end else begin
      miso_sync <= {miso_sync[0], link.miso};
    end
  end

  // host sequencer; sck half period is a divided enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= SFP_H_POWERUP;
      cnt <= '0;
      div <= '0;
      sck <= 1'b0;
      sel_n <= 1'b1;
      tx <= '0;
      bits_left <= '0;
      rx <= '0;
      rx_bits <= '0;
      hold_len <= '0;
      rd_len <= '0;
      sig_o <= '0;
      sig_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      sig_valid_o <= 1'b0;
      div <= tick ? 2'd0 : div + 2'd1;
      case (st)
        SFP_H_POWERUP: begin
          cnt <= cnt + SFP_DELAY_W'(1);
          if (cnt == SFP_DELAY_W'(SFP_SELECT_CYC)) begin
            st <= SFP_H_IDLE;
            req_ready_o <= 1'b1;
          end
        end
        SFP_H_IDLE: begin
          if (req_valid_i) begin
            req_ready_o <= 1'b0;
            sel_n <= 1'b0;
            tx <= req_op;
            bits_left <= req_bits;
            hold_len <= req_hold;
            rd_len <= req_rd;
            rx_bits <= '0;
            st <= SFP_H_SHIFT;
          end
        end
        SFP_H_SHIFT: begin
          if (tick) begin
            if (!sck && bits_left != 6'd0) begin
              sck <= 1'b1;
              bits_left <= bits_left - 6'd1;
            end else if (sck) begin
              sck <= 1'b0;
              tx <= {tx[6:0], 1'b0};
            end else begin
              // raise select right after the last bit
              sel_n <= 1'b1;
              cnt <= '0;
              st <= SFP_H_HOLD;
            end
            // reply crosses two flops each way, so a bit is taken three ticks
            // after its falling edge; the closing tick picks up the last one
            if (!sck && bits_left < rd_len) begin
              rx <= {rx[6:0], miso_sync[1]};
              rx_bits <= rx_bits + 3'd1;
              if (rx_bits == 3'd7) begin
                sig_o <= {rx[6:0], miso_sync[1]};
                sig_valid_o <= 1'b1;
              end
            end
          end
        end
        default: begin
          cnt <= cnt + SFP_DELAY_W'(1);
          if (cnt >= hold_len) begin
            st <= SFP_H_IDLE;
            req_ready_o <= 1'b1;
          end
        end
      endcase
    end
  end

  assign link.sel_n = sel_n;
  assign link.sck = sck;
  assign link.mosi = tx[7];
endmodule

// *** verif/sfp_link_props.sv ***
// concurrent checks on the spi link joining the host end and the device end
// assumes it sits beside the link interface, on the one system clock
`timescale 1ns/1ps
module sfp_link_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  import sfp_pkg::*;
  logic [15:0] up_cnt;
  logic [7:0] gap_cnt;
  logic [7:0] bit_cnt;
  logic sck_q;
  wire sck_rise = sck & ~sck_q;

  // age since reset, idle time with select high, clock edges in a frame
  // all saturate so a long idle spell cannot wrap into a false pass
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_cnt <= 16'h0000;
      gap_cnt <= 8'h00;
      bit_cnt <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      up_cnt <= (up_cnt == 16'hFFFF) ? up_cnt : up_cnt + 16'h0001;
      gap_cnt <= !sel_n ? 8'h00 : (gap_cnt == 8'hFF) ? gap_cnt : gap_cnt + 8'h01;
      bit_cnt <= sel_n ? 8'h00 : (bit_cnt == 8'hFF) ? bit_cnt : bit_cnt + {7'h00, sck_rise};
      sck_q <= sck;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // serial clock phases as the host walks each bit
  sequence s_sck_high2;
    sck[*2] ##1 !sck;
  endsequence
  sequence s_sck_low2;
    !sck[*2];
  endsequence

  a_sel_after_supply: assert property (!sel_n |-> up_cnt >= SFP_SELECT_CYC)
    else $error("select low too soon after reset");
  a_sck_idle_low: assert property (sel_n |-> !sck)
    else $error("serial clock moves while deselected");
  a_miso_release: assert property (sel_n[*4] |-> !miso_oe)
    else $error("device drives data while deselected");
  a_sck_high_two: assert property ($rose(sck) |-> s_sck_high2)
    else $error("serial clock high phase wrong");
  a_sck_low_two: assert property ($fell(sck) |-> s_sck_low2)
    else $error("serial clock low phase wrong");
  a_mosi_held_high: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data moves while clock high");
  a_sel_frame_gap: assert property ($fell(sel_n) |-> gap_cnt >= SFP_SLEEP_ENTRY_CYC - 1)
    else $error("select reopened inside the hold time");
  a_whole_bytes: assert property ($rose(sel_n) |-> bit_cnt[2:0] == 3'h0)
    else $error("frame closed off a byte boundary");
  a_oe_after_dummy: assert property (miso_oe && !sel_n |-> bit_cnt >= 8'h20)
    else $error("device drives before opcode and dummy bytes");
endmodule

// *** verif/testbench.sv ***
// self-checking bench: host end and device end joined over one link
// assumes a fault link where the bench drives a second device by hand
`timescale 1ns/1ps
module testbench;
  import sfp_pkg::*;
  localparam int WR_DELAY = 2000;
  localparam logic [7:0] WR_OPS [5] = '{SFP_CMD_UNLOCK, SFP_CMD_PAGE, SFP_CMD_SECTOR,
    SFP_CMD_FULL, SFP_CMD_STATUS};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic busy = 1'b0;
  logic req_valid = 1'b0;
  sfp_req_t req_cmd = SFP_REQ_SLEEP;
  logic [7:0] req_raw = 8'h00;
  logic [1:0] req_reads = 2'h0;
  logic tally_clr = 1'b0;
  logic req_ready, sig_valid, sleeping, busy_flag, latch, wr_ok, wr_valid, sleeping_f;
  logic [7:0] sig, status, wr_cmd, last_wr;
  int n_errors = 0;
  int checks = 0;
  int n_sig = 0;
  int sig_bad = 0;
  int n_wr = 0;
  int n_oe = 0;
  sfp_link_if u_link();
  sfp_link_if u_link_fault();

  always #20 clk = ~clk;

  sfp_host u_sfp_host (.sys_clk_i(clk), .rst_n_i(rst_n), .link(u_link),
    .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_raw_i(req_raw),
    .req_sig_reads_i(req_reads), .req_ready_o(req_ready), .sig_o(sig),
    .sig_valid_o(sig_valid));
  sfp_device #(.WRITE_DELAY_CYC(WR_DELAY)) u_sfp_device (.sys_clk_i(clk), .rst_n_i(rst_n),
    .link(u_link), .cycle_busy_i(busy), .sleeping_o(sleeping), .busy_flag_o(busy_flag),
    .write_unlock_latch_o(latch), .write_allowed_o(wr_ok), .status_o(status),
    .write_cmd_o(wr_cmd), .write_cmd_valid_o(wr_valid), .miso_o());
  // second device faces the bench, which breaks the framing on purpose
  sfp_device #(.WRITE_DELAY_CYC(WR_DELAY)) u_sfp_device_fault (.sys_clk_i(clk),
    .rst_n_i(rst_n), .link(u_link_fault), .cycle_busy_i(1'b0), .sleeping_o(sleeping_f),
    .busy_flag_o(), .write_unlock_latch_o(), .write_allowed_o(), .status_o(),
    .write_cmd_o(), .write_cmd_valid_o(), .miso_o());
  sfp_link_props u_props (.sys_clk_i(clk), .rst_n_i(rst_n), .sel_n(u_link.sel_n),
    .sck(u_link.sck), .mosi(u_link.mosi), .miso(u_link.miso), .miso_oe(u_link.miso_oe));

  // tally pulses so each scenario can judge its own frames
  // cleared at each take, so only this process writes the tallies
  always @(posedge clk) begin
    if (wr_valid === 1'b1) last_wr <= wr_cmd;
    if (tally_clr) begin
      n_sig <= 0;
      sig_bad <= 0;
      n_wr <= 0;
      n_oe <= 0;
    end else begin
      if (sig_valid === 1'b1) n_sig <= n_sig + 1;
      if (sig_valid === 1'b1 && sig !== SFP_SIGNATURE) sig_bad <= sig_bad + 1;
      if (wr_valid === 1'b1) n_wr <= n_wr + 1;
      if (u_link.miso_oe === 1'b1) n_oe <= n_oe + 1;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(req_ready, 1'b1);
  endtask
  // ready stands until taken, so the edge after valid rises takes it
  task automatic issue(input sfp_req_t cmd, input logic [7:0] raw, input logic [1:0] reads);
    wait_ready();
    @(posedge clk);
    tally_clr <= 1'b1;
    req_valid <= 1'b1;
    req_cmd <= cmd;
    req_raw <= raw;
    req_reads <= reads;
    @(posedge clk);
    tally_clr <= 1'b0;
    req_valid <= 1'b0;
  endtask
  task automatic send(input sfp_req_t cmd, input logic [7:0] raw, input logic [1:0] reads);
    issue(cmd, raw, reads);
    wait_ready();
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_power_up();
    chk_bit(sleeping, 1'b0);
    chk_bit(busy_flag, 1'b0);
    chk_bit(latch, 1'b0);
    chk(status, SFP_STATUS_RESET);
    chk_bit(wr_ok, 1'b0);
  endtask
  task automatic t_write_lockout();
    send(SFP_REQ_RAW, SFP_CMD_UNLOCK, 2'h0);
    chk(8'(n_wr), 8'h00);
    chk_bit(latch, 1'b0);
    for (int i = 0; i < 3000 && wr_ok !== 1'b1; i++) @(posedge clk);
    send(SFP_REQ_RAW, SFP_CMD_UNLOCK, 2'h0);
    chk(8'(n_wr), 8'h01);
    chk(last_wr, SFP_CMD_UNLOCK);
    chk_bit(wr_ok, 1'b1);
    chk_bit(latch, 1'b1);
  endtask
  task automatic t_sleep();
    issue(SFP_REQ_SLEEP, 8'h00, 2'h0);
    @(posedge u_link.sel_n);
    settle(SFP_SLEEP_ENTRY_CYC - 8);
    chk_bit(sleeping, 1'b0);
    wait_ready();
    settle(8);
    chk_bit(sleeping, 1'b1);
  endtask
  task automatic t_sleep_ignores();
    foreach (WR_OPS[i]) begin
      send(SFP_REQ_RAW, WR_OPS[i], 2'h0);
      chk(8'(n_wr), 8'h00);
      chk_bit(sleeping, 1'b1);
    end
  endtask
  task automatic t_wake(input logic [1:0] reads);
    send(SFP_REQ_WAKE, 8'h00, reads);
    settle(8);
    chk(8'(n_sig), {6'h00, reads});
    chk(8'(sig_bad), 8'h00);
    chk_bit(sleeping, 1'b0);
  endtask
  task automatic t_busy();
    @(posedge clk);
    busy <= 1'b1;
    settle(4);
    chk_bit(busy_flag, 1'b1);
    chk_bit(status[0], 1'b1);
    send(SFP_REQ_SLEEP, 8'h00, 2'h0);
    settle(8);
    chk_bit(sleeping, 1'b0);
    send(SFP_REQ_WAKE, 8'h00, 2'h1);
    chk(8'(n_oe), 8'h00);
    @(posedge clk);
    busy <= 1'b0;
    settle(4);
    chk_bit(busy_flag, 1'b0);
  endtask
  // hand-driven frame on the fault link, closed after nbits bits
  task automatic fault_frame(input logic [7:0] op, input int nbits);
    @(posedge clk);
    u_link_fault.sel_n <= 1'b0;
    for (int i = 7; i > 7 - nbits; i--) begin
      @(posedge clk);
      u_link_fault.mosi <= op[i];
      @(posedge clk);
      u_link_fault.sck <= 1'b1;
      repeat (2) @(posedge clk);
      u_link_fault.sck <= 1'b0;
    end
    repeat (2) @(posedge clk);
    u_link_fault.sel_n <= 1'b1;
    u_link_fault.mosi <= ~u_link_fault.mosi;
    settle(SFP_SLEEP_ENTRY_CYC + 10);
  endtask
  task automatic t_fault_reset();
    fault_frame(SFP_CMD_SLEEP, 6);
    chk_bit(sleeping_f, 1'b0);
    fault_frame(SFP_CMD_SLEEP, 8);
    chk_bit(sleeping_f, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    chk_bit(sleeping_f, 1'b0);
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // fault link idles deselected; the run needs some 4300 cycles
  initial begin
    u_link_fault.sel_n = 1'b1;
    u_link_fault.sck = 1'b0;
    u_link_fault.mosi = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    t_power_up();
    t_write_lockout();
    t_sleep();
    t_sleep_ignores();
    t_wake(2'h3);
    t_sleep();
    t_wake(2'h0);
    t_wake(2'h1);
    t_busy();
    t_fault_reset();
    finish_test();
  end
  initial begin
    #(40 * 40000);
    n_errors++;
    finish_test();
  end
endmodule
